// file: logic/tdh_engine.sv
// Purpose: Interpret and write back one 8-byte transfer descriptor header
// Assumes: Packet engine reports each transaction on txnDone with result
// Notes: Header loaded whole; written back whole on retire
//
// Behaviour
// - Header is eight bytes ahead of payload
// - Write bytes moved into transferred count
// - Status 0000 on clean completion
// - Status 0001 CRC, 0010 bit stuffing
// - Status 0011 on toggle mismatch
// - Status 0100 and retire on STALL
// - Status 0101 on no response
// - Status 0110 on PID check failure
// - Status 0111 on unexpected PID
// - Status 1000 on too much data
// - Status 1001 on short IN packet
// - Status 1100 when storing too slow
// - Status 1101 when fetching too slow
// - Run only active; clear active on completion
// - Keep expected toggle, flip per data packet without CRC, stuffing or toggle error
// - Last flag stops the list walk
`timescale 1ns/100ps
module tdh_engine
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic hdrLoad,
   input wire logic [63:0] hdrIn,
   input wire logic txnDone,
   input wire tdh_pkg::tdh_result_type txnResult,
   output logic txnRequest,
   output tdh_pkg::tdh_request_type request,
   output logic [9:0] remainingCount,
   output logic expectedToggle,
   output logic hdrValid,
   output logic [63:0] hdrOut,
   output logic retirePulse,
   output logic listEnd
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_RUN = 3'b010,
      S_DONE = 3'b100
   } tdh_state_type;

   tdh_state_type state_q;
   logic [63:0] hdr_q;
   logic [9:0] xferCnt_q;
   logic [3:0] status_q;
   logic toggle_q;
   logic retire_q;
   logic [3:0] errCode;
   logic finish;
   logic [10:0] newCnt;
   logic [9:0] reqCnt;

   assign request.maxPacketLen = hdr_q[tdh_pkg::POS_MAX_PKT +: 10];
   assign request.endpointIndex = hdr_q[tdh_pkg::POS_EP_INDEX +: 4];
   assign request.listLast = hdr_q[tdh_pkg::POS_LAST];
   assign request.lowSpeed = hdr_q[tdh_pkg::POS_SPEED];
   assign request.requestedCount = hdr_q[tdh_pkg::POS_REQ_CNT +: 10];
   assign request.tokenDirection = hdr_q[tdh_pkg::POS_TOKEN_DIR +: 2];
   assign request.singleInterruptTxn = hdr_q[tdh_pkg::POS_SINGLE_TXN];
   assign request.isoFormat = hdr_q[tdh_pkg::POS_FORMAT];
   assign request.deviceAddr = hdr_q[tdh_pkg::POS_DEV_ADDR +: 7];
   assign reqCnt = hdr_q[tdh_pkg::POS_REQ_CNT +: 10];

   // only an active header is executed
   assign txnRequest = (state_q == S_RUN);
   assign remainingCount = reqCnt - xferCnt_q;
   assign expectedToggle = toggle_q;
   assign hdrValid = (state_q == S_DONE);
   assign retirePulse = retire_q;
   // walk stops after a last-flagged header
   assign listEnd = (state_q == S_DONE) && request.listLast;
   assign newCnt = {1'b0, xferCnt_q} + {1'b0, txnResult.bytes};

   // Priority picks one code; handshake faults outrank data faults
   always_comb
   begin
      errCode = tdh_pkg::ST_OK;
      if (txnResult.stall)
         errCode = tdh_pkg::ST_STALL;
      else if (txnResult.noResp)
         errCode = tdh_pkg::ST_NO_RESP;
      else if (txnResult.pidCheckErr)
         errCode = tdh_pkg::ST_PID_CHECK;
      else if (txnResult.badPid)
         errCode = tdh_pkg::ST_BAD_PID;
      else if (txnResult.crcErr)
         errCode = tdh_pkg::ST_CRC;
      else if (txnResult.stuffErr)
         errCode = tdh_pkg::ST_STUFF;
      else if (txnResult.toggleErr)
         errCode = tdh_pkg::ST_TOGGLE;
      else if (txnResult.tooMuch || txnResult.bytes > request.maxPacketLen
               || newCnt > {1'b0, reqCnt})
         // more than packet size or room
         errCode = tdh_pkg::ST_TOO_MUCH;
      else if (txnResult.storeSlow)
         errCode = tdh_pkg::ST_STORE_SLOW;
      else if (txnResult.fetchSlow)
         errCode = tdh_pkg::ST_FETCH_SLOW;
      else if (request.tokenDirection == tdh_pkg::DIR_IN
               && txnResult.bytes < request.maxPacketLen
               && newCnt[9:0] < reqCnt)
         errCode = tdh_pkg::ST_SHORT;
   end

   // Done on error (short IN included), on full count, on isochronous format, or single interrupt txn
   assign finish = (errCode != tdh_pkg::ST_OK)
      || (newCnt[9:0] >= reqCnt)
      || request.isoFormat
      || request.singleInterruptTxn;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         state_q <= S_IDLE;
      else
      begin
         case (state_q)
            S_IDLE:
               if (hdrLoad && hdrIn[tdh_pkg::POS_ACTIVE])
                  state_q <= S_RUN;
            S_RUN:
               if (txnDone && finish)
                  state_q <= S_DONE;
            S_DONE:
               if (hdrLoad && hdrIn[tdh_pkg::POS_ACTIVE])
                  state_q <= S_RUN;
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         hdr_q <= tdh_pkg::HDR_RESET;
      else if (hdrLoad && state_q != S_RUN)
         hdr_q <= hdrIn;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         xferCnt_q <= 10'h000;
      else if (hdrLoad && state_q != S_RUN)
         xferCnt_q <= 10'h000;
      else if (state_q == S_RUN && txnDone)
         xferCnt_q <= (newCnt > {1'b0, reqCnt}) ? reqCnt : newCnt[9:0];
   end

   // only defined codes reach the status field
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         status_q <= tdh_pkg::ST_OK;
      else if (hdrLoad && state_q != S_RUN)
         status_q <= tdh_pkg::ST_OK;
      else if (state_q == S_RUN && txnDone)
         status_q <= errCode;
   end

   // toggle flips on each good data packet
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         toggle_q <= 1'b0;
      else if (hdrLoad && state_q != S_RUN)
         toggle_q <= hdrIn[tdh_pkg::POS_TOGGLE];
      else if (state_q == S_RUN && txnDone && txnResult.gotData
               && errCode != tdh_pkg::ST_TOGGLE
               && errCode != tdh_pkg::ST_CRC
               && errCode != tdh_pkg::ST_STUFF)
         toggle_q <= ~toggle_q;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         retire_q <= 1'b0;
      else
         retire_q <= (state_q == S_RUN) && txnDone && finish;
   end

   always_comb
   begin
      hdrOut = hdr_q;
      hdrOut[tdh_pkg::POS_XFER_CNT +: 10] = xferCnt_q;
      hdrOut[tdh_pkg::POS_TOGGLE] = toggle_q;
      hdrOut[tdh_pkg::POS_ACTIVE] = (state_q == S_RUN);
      hdrOut[tdh_pkg::POS_STATUS +: 4] = status_q;
      hdrOut[63:56] = 8'h00;
   end

   a_active_cleared: assert property (@(posedge mclk) disable iff (!nrst)
      retire_q |-> !hdrOut[tdh_pkg::POS_ACTIVE])
      else $error("active flag not cleared on retire");
   a_stall_retires: assert property (@(posedge mclk) disable iff (!nrst)
      (state_q == S_RUN && txnDone && txnResult.stall)
      |=> retire_q && status_q == tdh_pkg::ST_STALL)
      else $error("stall did not retire with status 0100");
   a_no_reserved: assert property (@(posedge mclk) disable iff (!nrst)
      status_q != 4'hA && status_q != 4'hB
      && status_q != 4'hE && status_q != 4'hF)
      else $error("reserved status code written");
   a_noresp_code: assert property (@(posedge mclk) disable iff (!nrst)
      (state_q == S_RUN && txnDone && txnResult.noResp)
      |=> status_q == tdh_pkg::ST_NO_RESP)
      else $error("no response not reported");
   a_crc_code: assert property (@(posedge mclk) disable iff (!nrst)
      (state_q == S_RUN && txnDone && errCode == tdh_pkg::ST_CRC)
      |=> status_q == tdh_pkg::ST_CRC && $stable(toggle_q))
      else $error("crc error mishandled");
   a_count_bound: assert property (@(posedge mclk) disable iff (!nrst)
      xferCnt_q <= reqCnt || state_q == S_IDLE)
      else $error("transferred count above requested");
   a_toggle_flip: assert property (@(posedge mclk) disable iff (!nrst)
      (state_q == S_RUN && txnDone && errCode == tdh_pkg::ST_OK
       && txnResult.gotData) |=> toggle_q != $past(toggle_q))
      else $error("toggle not updated");
   a_idle_quiet: assert property (@(posedge mclk) disable iff (!nrst)
      (hdrLoad && state_q != S_RUN && !hdrIn[tdh_pkg::POS_ACTIVE])
      |=> !txnRequest [*2])
      else $error("inactive header executed");
   a_reserved_byte: assert property (@(posedge mclk) disable iff (!nrst)
      hdrOut[63:56] == 8'h00)
      else $error("reserved byte not zero");
   a_last_stops: assert property (@(posedge mclk) disable iff (!nrst)
      (retire_q && request.listLast) |-> listEnd)
      else $error("list end not flagged");

   c_clean: cover property (@(posedge mclk) disable iff (!nrst)
      retire_q && status_q == tdh_pkg::ST_OK);
   c_short: cover property (@(posedge mclk) disable iff (!nrst)
      retire_q && status_q == tdh_pkg::ST_SHORT);
   c_stall: cover property (@(posedge mclk) disable iff (!nrst)
      retire_q && status_q == tdh_pkg::ST_STALL);
   c_multi: cover property (@(posedge mclk) disable iff (!nrst)
      txnDone && !finish && txnRequest);
endmodule

// file: shared/tdh_pkg.sv
// Purpose: Shared types and constants for the transfer descriptor header
// Assumes: 8-byte header, byte 0 first
// Notes: Field positions are bit indices within the 64-bit header image
package tdh_pkg;
   localparam int HDR_BYTES = 8;
   localparam int CNT_W = 10;
   // Field positions in the packed 64-bit header
   localparam int POS_XFER_CNT = 0;
   localparam int POS_TOGGLE = 10;
   localparam int POS_ACTIVE = 11;
   localparam int POS_STATUS = 12;
   localparam int POS_MAX_PKT = 16;
   localparam int POS_SPEED = 26;
   localparam int POS_LAST = 27;
   localparam int POS_EP_INDEX = 28;
   localparam int POS_REQ_CNT = 32;
   localparam int POS_TOKEN_DIR = 42;
   localparam int POS_SINGLE_TXN = 45;
   localparam int POS_DEV_ADDR = 48;
   localparam int POS_FORMAT = 55;
   // Completion status codes
   localparam logic [3:0] ST_OK = 4'h0;
   localparam logic [3:0] ST_CRC = 4'h1;
   localparam logic [3:0] ST_STUFF = 4'h2;
   localparam logic [3:0] ST_TOGGLE = 4'h3;
   localparam logic [3:0] ST_STALL = 4'h4;
   localparam logic [3:0] ST_NO_RESP = 4'h5;
   localparam logic [3:0] ST_PID_CHECK = 4'h6;
   localparam logic [3:0] ST_BAD_PID = 4'h7;
   localparam logic [3:0] ST_TOO_MUCH = 4'h8;
   localparam logic [3:0] ST_SHORT = 4'h9;
   localparam logic [3:0] ST_STORE_SLOW = 4'hC;
   localparam logic [3:0] ST_FETCH_SLOW = 4'hD;
   localparam logic [1:0] DIR_SETUP = 2'h0;
   localparam logic [1:0] DIR_OUT = 2'h1;
   localparam logic [1:0] DIR_IN = 2'h2;
   localparam logic [63:0] HDR_RESET = 64'h0;
   // Outcome of one transaction, reported by the packet engine
   typedef struct packed {
      logic crcErr;
      logic stuffErr;
      logic toggleErr;
      logic stall;
      logic noResp;
      logic pidCheckErr;
      logic badPid;
      logic tooMuch;
      logic storeSlow;
      logic fetchSlow;
      logic gotData;
      logic [9:0] bytes;
   } tdh_result_type;
   // Request fields decoded from the header
   typedef struct packed {
      logic [9:0] maxPacketLen;
      logic [3:0] endpointIndex;
      logic listLast;
      logic lowSpeed;
      logic [9:0] requestedCount;
      logic [1:0] tokenDirection;
      logic singleInterruptTxn;
      logic isoFormat;
      logic [6:0] deviceAddr;
   } tdh_request_type;
endpackage

// file: tb/tdh_driver_model.sv
// Purpose: Driver and packet engine stand-in for the header engine
// Assumes: Drives on the falling edge of mclk
// Notes: Idle data lines show inverted values, never stale ones
`timescale 1ns/100ps
module tdh_driver_model
(
   input wire logic mclk,
   input wire logic txnRequest,
   output logic hdrLoad,
   output logic [63:0] hdrIn,
   output logic txnDone,
   output tdh_pkg::tdh_result_type txnResult
);
   logic [1:0] tokenDir;
   logic oneTxn;
   initial
   begin
      hdrLoad = 1'h0;
      hdrIn = 64'h0;
      txnDone = 1'h0;
      txnResult = '0;
      tokenDir = 2'h2;
      oneTxn = 1'h0;
   end
   // direction and single transaction flag for later loads
   task automatic set_mode(input logic [1:0] dir, input logic one);
      tokenDir = dir;
      oneTxn = one;
   endtask
   task automatic load(input logic act, tog, last, fmt,
      input logic [9:0] mx, req);
      @(negedge mclk);
      hdrIn = {8'hA5, fmt, 7'h12, 2'h0, oneTxn, 1'h0, tokenDir, req,
         4'h3, last, 1'h0, mx, 4'hF, act, tog, 10'h000};
      hdrLoad = 1'h1;
      @(negedge mclk);
      hdrLoad = 1'h0;
      hdrIn = ~hdrIn;
   endtask
   // Slow answers come from gap; waits for a run request after the gap
   task automatic txn(input int gap, input logic [9:0] flags,
      input logic got, input logic [9:0] n);
      int k;
      k = 0;
      // One idle edge first, so txnDone never drops and rises in one step
      @(negedge mclk);
      repeat (gap) @(negedge mclk);
      while (txnRequest !== 1'h1 && k < 50)
      begin
         @(negedge mclk);
         k++;
      end
      txnResult = tdh_pkg::tdh_result_type'({flags, got, n});
      txnDone = 1'h1;
      @(negedge mclk);
      txnDone = 1'h0;
      txnResult = ~txnResult;
   endtask
endmodule

// file: tb/tdh_engine_bench.sv
// Purpose: Self-checking bench for the header engine
// Assumes: 100 MHz mclk, reset held 16 cycles
// Notes: Checks sampled at the falling edge, after updates settle
`timescale 1ns/100ps
module tdh_engine_bench;
   logic mclk, nrst, hdrLoad, txnDone, txnRequest, expectedToggle;
   logic hdrValid, retirePulse, listEnd;
   logic [63:0] hdrIn, hdrOut;
   logic [9:0] remainingCount;
   tdh_pkg::tdh_result_type txnResult;
   tdh_pkg::tdh_request_type request;
   int mismatches, n_checks;
   logic [3:0] errCode [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
      4'h7, 4'h8, 4'hC, 4'hD};
   tdh_engine DUT (.mclk(mclk), .nrst(nrst), .hdrLoad(hdrLoad),
      .hdrIn(hdrIn), .txnDone(txnDone), .txnResult(txnResult),
      .txnRequest(txnRequest), .request(request),
      .remainingCount(remainingCount), .expectedToggle(expectedToggle),
      .hdrValid(hdrValid), .hdrOut(hdrOut), .retirePulse(retirePulse),
      .listEnd(listEnd));
   tdh_driver_model DRV (.mclk(mclk), .txnRequest(txnRequest),
      .hdrLoad(hdrLoad), .hdrIn(hdrIn), .txnDone(txnDone),
      .txnResult(txnResult));
   initial
   begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [63:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic done(input logic [9:0] cnt, input logic [3:0] st,
      input logic tog);
      chk("retirePulse", 1'h1, retirePulse);
      chk("hdrValid", 1'h1, hdrValid);
      chk("txnRequest", 1'h0, txnRequest);
      chk("count", cnt, hdrOut[9:0]);
      chk("status", st, hdrOut[15:12]);
      chk("active", 1'h0, hdrOut[11]);
      chk("toggle", tog, hdrOut[10]);
      chk("byte7", 8'h00, hdrOut[63:56]);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog sized well above the roughly 140 cycles of the tests
   initial
   begin
      repeat (3000) @(posedge mclk);
      mismatches++;
      print_verdict();
   end
   initial
   begin
      mismatches = 0;
      n_checks = 0;
      nrst = 1'h0;
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'h1;
      // Clean single packet, last of its list
      DRV.load(1'h1, 1'h0, 1'h1, 1'h0, 10'h8, 10'h8);
      chk("request", {10'h8, 4'h3, 1'h1, 1'h0, 10'h8, 2'h2, 1'h0,
         1'h0, 7'h12}, request);
      chk("run", 1'h1, txnRequest);
      chk("expToggle", 1'h0, expectedToggle);
      DRV.txn(0, 10'h0, 1'h1, 10'h8);
      done(10'h8, 4'h0, 1'h1);
      chk("listEnd", 1'h1, listEnd);
      @(negedge mclk);
      chk("pulseEnd", 1'h0, retirePulse);
      // Bulk transfer in two packets, first answer slow
      DRV.load(1'h1, 1'h1, 1'h0, 1'h0, 10'h8, 10'h10);
      DRV.txn(3, 10'h0, 1'h1, 10'h8);
      chk("run", 1'h1, txnRequest);
      chk("remaining", 10'h8, remainingCount);
      chk("expToggle", 1'h0, expectedToggle);
      DRV.txn(0, 10'h0, 1'h1, 10'h8);
      done(10'h10, 4'h0, 1'h1);
      chk("listEnd", 1'h0, listEnd);
      // Short packet leaves the buffer unfilled
      DRV.load(1'h1, 1'h0, 1'h0, 1'h0, 10'h8, 10'h10);
      DRV.txn(0, 10'h0, 1'h1, 10'h4);
      done(10'h4, 4'h9, 1'h1);
      // More data than the room left; count is clamped
      DRV.load(1'h1, 1'h0, 1'h0, 1'h0, 10'h8, 10'h4);
      DRV.txn(0, 10'h0, 1'h1, 10'h6);
      done(10'h4, 4'h8, 1'h1);
      // One error flag at a time, gap grows with the index
      for (int i = 0; i < 10; i++)
      begin
         DRV.load(1'h1, 1'h1, 1'h0, 1'h0, 10'h8, 10'h8);
         DRV.txn(i, 10'h200 >> i, 1'h0, 10'h0);
         done(10'h0, errCode[i], 1'h1);
      end
      // Reset in mid-run drops the running header and all outputs
      DRV.load(1'h1, 1'h0, 1'h1, 1'h0, 10'h8, 10'h8);
      nrst = 1'h0;
      @(negedge mclk);
      chk("rstRun", 1'h0, txnRequest);
      chk("rstValid", 1'h0, hdrValid);
      chk("rstPulse", 1'h0, retirePulse);
      chk("rstEnd", 1'h0, listEnd);
      chk("rstImage", 64'h0, hdrOut);
      @(negedge mclk);
      nrst = 1'h1;
      // Isochronous header retires after one packet
      DRV.load(1'h1, 1'h0, 1'h1, 1'h1, 10'h8, 10'h10);
      DRV.txn(0, 10'h0, 1'h1, 10'h8);
      done(10'h8, 4'h0, 1'h1);
      chk("listEnd", 1'h1, listEnd);
      // Single interrupt transaction; a short OUT is no underrun
      DRV.set_mode(tdh_pkg::DIR_OUT, 1'h1);
      DRV.load(1'h1, 1'h0, 1'h0, 1'h0, 10'h8, 10'h10);
      chk("direction", 2'h1, request.tokenDirection);
      chk("single", 1'h1, request.singleInterruptTxn);
      DRV.txn(0, 10'h0, 1'h0, 10'h4);
      done(10'h4, 4'h0, 1'h0);
      DRV.set_mode(tdh_pkg::DIR_IN, 1'h0);
      // Inactive header must not start transactions
      DRV.load(1'h0, 1'h0, 1'h0, 1'h0, 10'h8, 10'h8);
      repeat (3) @(negedge mclk);
      chk("idle", 1'h0, txnRequest);
      print_verdict();
   end
endmodule
